/* logic/awt_pkg.sv */
// package: register map, fields and timing constants for the watchdog timer
package awt_pkg;
    localparam logic [7:0] AWT_OFF_UNITS   = 8'hf1;
    localparam logic [7:0] AWT_OFF_COUNT   = 8'hf2;
    localparam logic [7:0] AWT_OFF_CONFIG  = 8'hf3;
    localparam logic [7:0] AWT_OFF_CONTROL = 8'hf4;
    localparam logic [7:0] AWT_OFF_IRQ_ST  = 8'hf8;
    localparam logic [7:0] AWT_OFF_IRQ_MSK = 8'hf9;
    localparam int         AWT_UNITS_SEL_BIT  = 7;
    localparam int         AWT_CFG_GAME_BIT   = 0;
    localparam int         AWT_CFG_KBD_BIT    = 1;
    localparam int         AWT_CFG_MOUSE_BIT  = 2;
    localparam int         AWT_CFG_MAP_LSB    = 4;
    localparam int         AWT_CTL_STATUS_BIT = 0;
    localparam int         AWT_CTL_FORCE_BIT  = 2;
    localparam int         AWT_CTL_EXTEN_BIT  = 3;
    localparam logic [7:0] AWT_RESET_VALUE    = 8'h00;
    localparam logic [7:0] AWT_CTL_RW_MASK    = 8'h09;
    localparam logic [3:0] AWT_MAP_DISABLE    = 4'h0;
    localparam logic [3:0] AWT_MAP_INVALID    = 4'h2;
    localparam longint     AWT_CLK_HZ         = 200000000;
    localparam longint     AWT_SECOND_S       = 1;
    localparam longint     AWT_MINUTE_S       = 60;
    localparam longint     AWT_SECOND_CYCLES  = AWT_CLK_HZ * AWT_SECOND_S;
    localparam int         AWT_SEC_PER_MIN    = int'(AWT_MINUTE_S / AWT_SECOND_S);
endpackage

/* logic/awt_watchdog.sv */
// module: auxiliary watchdog timer with avalon-mm register slave
//
// Contract
// - units bit 7 clear counts minutes, set counts seconds.
// - zero timeout count never expires.
// - nonzero count is unsigned units, one to 255.
// - game-port access restarts count when its enable is set.
// - keyboard interrupt restarts count when its enable is set.
// - mouse interrupt restarts count when its enable is set.
// - mapping field n drives irq n; zero disables, two invalid.
// - status bit reads one after timeout, zero while counting.
// - writing force bit makes a timeout; bit clears itself.
// - enabled rising edge of kbc force line makes a timeout.
// - edge detector pulse ored with software force pulse.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module awt_watchdog
    import awt_pkg::*;
#(
    parameter longint SECOND_CYCLES = AWT_SECOND_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        host_rst_b_in,
    input  wire logic        standby_rst_b_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        game_port_access_in,
    input  wire logic        kbd_irq_in,
    input  wire logic        mouse_irq_in,
    input  wire logic        kbc_force_line_in,
    output logic      [15:0] isa_irq_out,
    output logic             irq_out
);
    typedef enum logic [0:0] {
        AWT_BUS_IDLE = 1'b0,
        AWT_BUS_ACK  = 1'b1
    } awt_bus_state_t;

    localparam int NUM_PINS  = 4;
    localparam int NUM_ISA   = 16;
    localparam int PIN_GAME  = 0;
    localparam int PIN_KBD   = 1;
    localparam int PIN_MOUSE = 2;
    localparam int PIN_FORCE = 3;

    awt_bus_state_t      bus_state_q;
    awt_bus_state_t      bus_state_d;
    logic                units_q;
    logic [7:0]          count_q;
    logic [7:0]          config_q;
    logic                status_q;
    logic                ext_en_q;
    logic [1:0]          irq_st_q;
    logic [1:0]          irq_msk_q;
    logic [31:0]         rdata_q;
    logic [31:0]         tick_q;
    logic [5:0]          sec_q;
    logic [7:0]          units_done_q;
    logic [NUM_ISA-1:0]  isa_sel;
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_rise;
    logic [3:0]          irq_map;
    logic                main_rst_b;
    logic                ctl_rst_b;
    logic                req;
    logic                ack;
    logic                wr_ok;
    logic                rd_ok;
    logic                wr_units;
    logic                wr_count;
    logic                wr_config;
    logic                wr_control;
    logic                wr_irq_msk;
    logic                rd_irq_st;
    logic                irq_line_on;
    logic                counter_clear;
    logic                restart;
    logic                force_pulse;
    logic                ext_pulse;
    logic                expire;
    logic                timeout;
    logic                unit_tick;
    logic                sec_tick;

    // host reset clears units, count and config but leaves the control register, the status of a past timeout included
    assign main_rst_b = rst_b_in & host_rst_b_in;
    assign ctl_rst_b  = standby_rst_b_in;

    assign req = avs_read_in | avs_write_in;
    assign ack = (bus_state_q == AWT_BUS_ACK);

    always_comb begin
        bus_state_d = bus_state_q;
        unique case (bus_state_q)
            AWT_BUS_IDLE: begin
                if (req) begin
                    bus_state_d = AWT_BUS_ACK;
                end
            end
            AWT_BUS_ACK: begin
                bus_state_d = AWT_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_state_q <= AWT_BUS_IDLE;
        end else begin
            bus_state_q <= bus_state_d;
        end
    end

    // single wait state: every access completes one edge after it is seen
    assign avs_waitrequest_out = req & ~ack;
    assign wr_ok               = avs_write_in & ack & avs_byteenable_in[0];
    // read data latched at the first edge, so it stands when waitrequest drops
    assign rd_ok               = avs_read_in & ~ack;
    assign avs_readdata_out    = rdata_q;

    assign wr_units   = wr_ok & (avs_address_in == AWT_OFF_UNITS);
    assign wr_count   = wr_ok & (avs_address_in == AWT_OFF_COUNT);
    assign wr_config  = wr_ok & (avs_address_in == AWT_OFF_CONFIG);
    assign wr_control = wr_ok & (avs_address_in == AWT_OFF_CONTROL);
    assign wr_irq_msk = wr_ok & (avs_address_in == AWT_OFF_IRQ_MSK);
    assign rd_irq_st  = rd_ok & (avs_address_in == AWT_OFF_IRQ_ST);

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_ok) begin
            unique case (avs_address_in)
                AWT_OFF_UNITS:   rdata_q <= {24'h00_0000, units_q, 7'h00};
                AWT_OFF_COUNT:   rdata_q <= {24'h00_0000, count_q};
                AWT_OFF_CONFIG:  rdata_q <= {24'h00_0000, irq_map, 1'b0, config_q[2:0]};
                AWT_OFF_CONTROL: rdata_q <= {28'h000_0000, ext_en_q, 2'b00, status_q};
                AWT_OFF_IRQ_ST:  rdata_q <= {30'h0000_0000, irq_st_q};
                AWT_OFF_IRQ_MSK: rdata_q <= {30'h0000_0000, irq_msk_q};
                default:         rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge main_rst_b) begin
        if (!main_rst_b) begin
            units_q <= 1'b0;
        end else if (wr_units) begin
            units_q <= avs_writedata_in[AWT_UNITS_SEL_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge main_rst_b) begin
        if (!main_rst_b) begin
            count_q <= AWT_RESET_VALUE;
        end else if (wr_count) begin
            count_q <= avs_writedata_in[7:0];
        end
    end

    // bit 3 is reserved and kept at zero
    always_ff @(posedge ref_clk_in or negedge main_rst_b) begin
        if (!main_rst_b) begin
            config_q <= AWT_RESET_VALUE;
        end else if (wr_config) begin
            config_q <= avs_writedata_in[7:0] & 8'hf7;
        end
    end

    assign irq_map = config_q[AWT_CFG_MAP_LSB +: 4];

    assign pin_raw[PIN_GAME]  = game_port_access_in;
    assign pin_raw[PIN_KBD]   = kbd_irq_in;
    assign pin_raw[PIN_MOUSE] = mouse_irq_in;
    assign pin_raw[PIN_FORCE] = kbc_force_line_in;

    // two flip-flops against metastability; the third only holds the last level
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        logic [2:0] sync_q;

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                sync_q <= 3'h0;
            end else begin
                sync_q <= {sync_q[1:0], pin_raw[g]};
            end
        end

        // reset level equals the idle pin level, so no false edge after reset
        assign pin_rise[g] = sync_q[1] & ~sync_q[2];
    end

    assign restart = (config_q[AWT_CFG_GAME_BIT] & pin_rise[PIN_GAME])
                   | (config_q[AWT_CFG_KBD_BIT] & pin_rise[PIN_KBD])
                   | (config_q[AWT_CFG_MOUSE_BIT] & pin_rise[PIN_MOUSE])
                   | wr_count;

    // level-held force line fires once per rising edge
    assign ext_pulse   = ext_en_q & pin_rise[PIN_FORCE];
    assign force_pulse = wr_control & avs_writedata_in[AWT_CTL_FORCE_BIT];
    assign timeout     = force_pulse | ext_pulse | expire;

    assign sec_tick  = (tick_q == 32'(SECOND_CYCLES - 1));
    assign unit_tick = sec_tick & (units_q | (sec_q == 6'(AWT_SEC_PER_MIN - 1)));
    assign expire    = unit_tick & (count_q != 8'h00) & ~status_q
                     & (units_done_q == count_q - 8'h01);
    // held at zero while disabled or expired, so clearing status restarts fresh
    assign counter_clear = restart | (count_q == 8'h00) | status_q;

    always_ff @(posedge ref_clk_in or negedge main_rst_b) begin
        if (!main_rst_b) begin
            tick_q <= 32'h0000_0000;
        end else if (counter_clear | sec_tick) begin
            tick_q <= 32'h0000_0000;
        end else begin
            tick_q <= tick_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge main_rst_b) begin
        if (!main_rst_b) begin
            sec_q <= 6'h00;
        end else if (counter_clear | unit_tick) begin
            sec_q <= 6'h00;
        end else if (sec_tick) begin
            sec_q <= sec_q + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_in or negedge main_rst_b) begin
        if (!main_rst_b) begin
            units_done_q <= 8'h00;
        end else if (counter_clear) begin
            units_done_q <= 8'h00;
        end else if (unit_tick) begin
            units_done_q <= units_done_q + 8'h01;
        end
    end

    // a timeout in the same cycle as a software clear wins
    always_ff @(posedge ref_clk_in or negedge ctl_rst_b) begin
        if (!ctl_rst_b) begin
            status_q <= 1'b0;
        end else if (timeout) begin
            status_q <= 1'b1;
        end else if (wr_control) begin
            status_q <= avs_writedata_in[AWT_CTL_STATUS_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge ctl_rst_b) begin
        if (!ctl_rst_b) begin
            ext_en_q <= 1'b0;
        end else if (wr_control) begin
            ext_en_q <= avs_writedata_in[AWT_CTL_EXTEN_BIT];
        end
    end

    assign irq_line_on = status_q & (irq_map != AWT_MAP_DISABLE)
                       & (irq_map != AWT_MAP_INVALID);

    // code two is refused: no line is driven rather than a guessed one
    for (genvar n = 0; n < NUM_ISA; n++) begin : g_isa
        assign isa_sel[n] = irq_line_on & (irq_map == 4'(n));
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            isa_irq_out <= 16'h0000;
        end else begin
            isa_irq_out <= isa_sel;
        end
    end

    // bit0 timeout event, bit1 restart event; an event beside the clearing read stays
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_st_q <= 2'b00;
        end else if (rd_irq_st) begin
            irq_st_q <= {restart, timeout};
        end else begin
            irq_st_q <= irq_st_q | {restart, timeout};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_msk_q <= 2'b00;
        end else if (wr_irq_msk) begin
            irq_msk_q <= avs_writedata_in[1:0];
        end
    end

    // level output; software must read the status to drop it
    assign irq_out = |(irq_st_q & irq_msk_q);

endmodule

/* tb/awt_watchdog_props.sv */
// assertions on the watchdog register port and interrupt lines
`timescale 1ns/1ps
module awt_watchdog_props
    import awt_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        rst_b_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic [15:0] isa_irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic req = avs_read_in | avs_write_in;
    sequence rd_done(a);
        avs_read_in && !avs_waitrequest_out && avs_address_in == a;
    endsequence
    sequence clr_wr;
        avs_write_in && !avs_waitrequest_out && avs_address_in == AWT_OFF_CONTROL
            && avs_writedata_in[2:0] == 3'h0 && avs_byteenable_in[0];
    endsequence
    wait_one_a: assert property ($rose(req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("waitrequest not low in second cycle");
    idle_free_a: assert property (!req |-> !avs_waitrequest_out) else $error("waitrequest without request");
    irq_one_a: assert property ($onehot0(isa_irq_out)) else $error("several isa lines high");
    irq_skip_a: assert property (!isa_irq_out[0] && !isa_irq_out[2]) else $error("isa line 0 or 2 high");
    units_res_a: assert property (rd_done(AWT_OFF_UNITS) |-> avs_readdata_out[6:0] == 7'h0
        && avs_readdata_out[31:8] == 24'h0) else $error("units reserved bits set");
    ctrl_res_a: assert property (rd_done(AWT_OFF_CONTROL) |-> avs_readdata_out[31:4] == 28'h0
        && !avs_readdata_out[2]) else $error("control force or reserved bit reads one");
    rdata_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out)) else $error("read data moved");
    irq_clear_a: assert property (clr_wr |-> ##2 isa_irq_out == 16'h0) else $error("isa line after clear");
    unmapped_a: assert property (avs_read_in && !avs_waitrequest_out
        && !(avs_address_in inside {8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf8, 8'hf9})
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
endmodule
bind awt_watchdog awt_watchdog_props i_awt_watchdog_props (
    .ref_clk_in          (ref_clk_in),
    .rst_b_in            (rst_b_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .isa_irq_out         (isa_irq_out)
);

/* tb/awt_far_model.sv */
// far side model: game port, keyboard and mouse interrupts, force line
`timescale 1ns/1ps
module awt_far_model #(
    parameter int HOLD = 200
) (
    input  wire logic       ref_clk_in,
    input  wire logic [3:0] go_in,
    output logic      [3:0] line_out
);
    int cnt_q [4] = '{0, 0, 0, 0};
    // force line held a full microsecond; irq lines short so edges can repeat
    always_ff @(posedge ref_clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (go_in[i]) cnt_q[i] <= (i == 3) ? HOLD : 4;
            else if (cnt_q[i] > 0) cnt_q[i] <= cnt_q[i] - 1;
        end
    end
    always_comb for (int i = 0; i < 4; i++) line_out[i] = cnt_q[i] > 0;
endmodule

/* tb/tb.sv */
// testbench: register, restart, force and interrupt checks for the watchdog
`timescale 1ns/1ps
module tb;
    import awt_pkg::*;
    localparam int SEC = 20;
    logic        clk = 0, rst_b = 0, host_b = 0, sb_b = 0, rd = 0, wr = 0, wrq, irq;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wd = 32'h0, rdata, rdo;
    logic [3:0]  go = 4'h0, line, be = 4'h1;
    logic [15:0] isa;
    int          err_total = 0, samples_checked = 0;
    awt_watchdog #(.SECOND_CYCLES(SEC)) i_awt_watchdog (.ref_clk_in(clk), .rst_b_in(rst_b),
        .host_rst_b_in(host_b), .standby_rst_b_in(sb_b), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdo),
        .avs_waitrequest_out(wrq), .game_port_access_in(line[0]), .kbd_irq_in(line[1]),
        .mouse_irq_in(line[2]), .kbc_force_line_in(line[3]), .isa_irq_out(isa), .irq_out(irq));
    awt_far_model i_awt_far_model (.ref_clk_in(clk), .go_in(go), .line_out(line));
    initial forever #2.5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        adr <= a; wd <= {24'h0, d}; rd <= !w; wr <= w;
        do begin
            @(posedge clk);
        end while (wrq !== 1'b0);
        rdata = rdo;
        rd <= 1'b0; wr <= 1'b0; @(posedge clk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 8'h0); chk(rdata, exp);
    endtask
    task pulse(input int i);
        go[i] <= 1'b1; @(posedge clk); go[i] <= 1'b0;
    endtask
    task summarize;
        $display("mismatches %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100000; err_total++; summarize;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1; host_b <= 1'b1; sb_b <= 1'b1; @(posedge clk);
        for (int a = 8'hf1; a <= 8'hf4; a++) rchk(8'(a), 32'h0);
        rchk(8'h10, 32'h0);
        acc(1'b1, AWT_OFF_UNITS, 8'h80); acc(1'b1, AWT_OFF_COUNT, 8'h0); repeat (100) @(posedge clk);
        rchk(AWT_OFF_CONTROL, 32'h0);
        acc(1'b1, AWT_OFF_CONFIG, 8'h30); acc(1'b1, AWT_OFF_COUNT, 8'h02); repeat (2 * SEC - 10) @(posedge clk);
        rchk(AWT_OFF_CONTROL, 32'h0);
        repeat (15) @(posedge clk); rchk(AWT_OFF_CONTROL, 32'h1);
        chk(32'(isa), 32'h8);
        // second three passes leave every reload enable clear
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, AWT_OFF_CONFIG, 8'h30 | ((i < 3) ? 8'h01 << i : 8'h00));
            acc(1'b1, AWT_OFF_CONTROL, 8'h0); acc(1'b1, AWT_OFF_COUNT, 8'h02);
            repeat (30) @(posedge clk); pulse(i % 3); repeat (25) @(posedge clk);
            rchk(AWT_OFF_CONTROL, (i < 3) ? 32'h0 : 32'h1);
        end
        acc(1'b1, AWT_OFF_UNITS, 8'h0); acc(1'b1, AWT_OFF_CONTROL, 8'h0); acc(1'b1, AWT_OFF_COUNT, 8'h01);
        repeat (60 * SEC - 100) @(posedge clk); rchk(AWT_OFF_CONTROL, 32'h0);
        repeat (120) @(posedge clk); rchk(AWT_OFF_CONTROL, 32'h1);
        acc(1'b1, AWT_OFF_COUNT, 8'h0); acc(1'b1, AWT_OFF_CONTROL, 8'h0); acc(1'b1, AWT_OFF_CONTROL, 8'h04);
        rchk(AWT_OFF_CONTROL, 32'h1);
        acc(1'b1, AWT_OFF_CONTROL, 8'h0); pulse(3); repeat (5) @(posedge clk);
        rchk(AWT_OFF_CONTROL, 32'h0);
        acc(1'b1, AWT_OFF_CONTROL, 8'h08); repeat (5) @(posedge clk);
        rchk(AWT_OFF_CONTROL, 32'h08);
        repeat (200) @(posedge clk); pulse(3); repeat (5) @(posedge clk);
        rchk(AWT_OFF_CONTROL, 32'h09);
        for (int n = 0; n < 16; n++) begin
            acc(1'b1, AWT_OFF_CONFIG, 8'(n << 4)); repeat (3) @(posedge clk);
            chk(32'(isa), (n == 0 || n == 2) ? 32'h0 : 32'h1 << n);
        end
        acc(1'b1, AWT_OFF_IRQ_MSK, 8'h01); acc(1'b1, AWT_OFF_CONTROL, 8'h0);
        acc(1'b0, AWT_OFF_IRQ_ST, 8'h0); repeat (2) @(posedge clk); chk(32'(irq), 32'h0);
        acc(1'b1, AWT_OFF_CONTROL, 8'h04); repeat (2) @(posedge clk); chk(32'(irq), 32'h1);
        acc(1'b0, AWT_OFF_IRQ_ST, 8'h0); chk(32'(rdata[0]), 32'h1);
        repeat (2) @(posedge clk); chk(32'(irq), 32'h0);
        acc(1'b1, AWT_OFF_COUNT, 8'h05); host_b <= 1'b0; @(posedge clk); host_b <= 1'b1; @(posedge clk);
        rchk(AWT_OFF_COUNT, 32'h0); rchk(AWT_OFF_CONTROL, 32'h1);
        be <= 4'h0; acc(1'b1, AWT_OFF_COUNT, 8'h07); be <= 4'h1; rchk(AWT_OFF_COUNT, 32'h0);
        sb_b <= 1'b0; @(posedge clk); sb_b <= 1'b1; @(posedge clk);
        rchk(AWT_OFF_CONTROL, 32'h0);
        acc(1'b1, AWT_OFF_CONTROL, 8'h01); rchk(AWT_OFF_CONTROL, 32'h1);
        summarize;
    end
endmodule
